/* File: verilog/psmc_consts.vh */
// Constants for the power saving mode controller
`ifndef PSMC_CONSTS_VH
`define PSMC_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PSMC_ADDR_CLK_STATUS 4'h0
`define PSMC_ADDR_MODE 4'h1
`define PSMC_ADDR_CC 4'h2
`define PSMC_ADDR_STAB_CNT 4'h3

// ----------------------------------------
// Field positions in main clock status register
// ----------------------------------------
`define PSMC_BIT_OIE 0
`define PSMC_BIT_SMS 1
`define PSMC_BIT_CP_LO 2
`define PSMC_BIT_CP_HI 3
`define PSMC_BIT_STAB_LONG 4

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define PSMC_CLK_STATUS_RST 8'h00
`define PSMC_PRIO_OPEN 2'h2
`define PSMC_PRIO_MASKED 2'h3

// ----------------------------------------
// Mode codes
// ----------------------------------------
`define PSMC_MODE_RUN 3'h0
`define PSMC_MODE_WAIT 3'h1
`define PSMC_MODE_AHALT 3'h2
`define PSMC_MODE_HALT 3'h3
`define PSMC_MODE_STAB 3'h4

// ----------------------------------------
// Stabilisation delay in CPU cycles
// ----------------------------------------
`define PSMC_STAB_SHORT 13'h0100
`define PSMC_STAB_LONG 13'h1000

`endif

/* File: verilog/psmc_top.v */
// Power saving mode controller: run, slow, wait, active-halt and halt
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "psmc_consts.vh"

module psmc_top #(
  parameter STAB_SHORT_CYC = 256,
  parameter STAB_LONG_CYC = 4096
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // CPU core events
  input wire wait_for_interrupt_instr,
  input wire halt_instr,
  input wire irq_pending,
  input wire irq_timebase,
  input wire irq_halt_wake,
  input wire [1:0] irq_prio,
  input wire irq_enter,
  input wire cc_pop,
  input wire [1:0] cc_pop_prio,
  input wire wake_by_reset,
  input wire watchdog_reset_req,
  // Clock gates and status
  output reg cpu_clk_en,
  output reg periph_clk_en,
  output reg osc_en,
  output reg timebase_clk_en,
  output reg [1:0] cc_prio,
  output reg [1:0] cc_pushed_prio,
  output reg cc_push,
  output reg vector_fetch,
  output reg watchdog_reset,
  output reg [2:0] mode
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [7:0] clk_status_reg;
  reg [7:0] clk_status_next;
  reg [2:0] mode_reg;
  reg [2:0] mode_next;
  reg [1:0] prio_reg;
  reg [1:0] prio_next;
  reg [12:0] stab_cnt_reg;
  reg [12:0] stab_cnt_next;
  reg [3:0] div_cnt_reg;
  reg [3:0] div_cnt_next;
  reg stab_from_ahalt_reg;
  reg stab_from_ahalt_next;
  reg [3:0] div_mask;
  reg div_tick;
  reg [12:0] stab_len;

  wire oscillator_interrupt_enable = clk_status_reg[`PSMC_BIT_OIE];
  wire slow_mode_enable = clk_status_reg[`PSMC_BIT_SMS];
  wire [1:0] cp = clk_status_reg[`PSMC_BIT_CP_HI:`PSMC_BIT_CP_LO];

  // ----------------------------------------
  // Slow clock divider
  // ----------------------------------------
  always @* begin
    case (cp)
      2'h0: div_mask = 4'h1;
      2'h1: div_mask = 4'h3;
      2'h2: div_mask = 4'h7;
      default: div_mask = 4'hf;
    endcase
    div_tick = !slow_mode_enable || ((div_cnt_reg & div_mask) == div_mask);
    div_cnt_next = slow_mode_enable ? div_cnt_reg + 4'h1 : 4'h0;
    stab_len = clk_status_reg[`PSMC_BIT_STAB_LONG] ? STAB_LONG_CYC[12:0] : STAB_SHORT_CYC[12:0];
  end

  // ----------------------------------------
  // Mode sequencing
  // ----------------------------------------
  always @* begin
    mode_next = mode_reg;
    prio_next = prio_reg;
    stab_cnt_next = stab_cnt_reg;
    stab_from_ahalt_next = stab_from_ahalt_reg;
    clk_status_next = clk_status_reg;
    if (reg_wr && reg_addr == `PSMC_ADDR_CLK_STATUS) begin
      clk_status_next = reg_wdata;
    end
    if (irq_enter) begin
      prio_next = irq_prio;
    end else if (cc_pop) begin
      prio_next = cc_pop_prio;
    end
    case (mode_reg)
      `PSMC_MODE_RUN: begin
        if (wait_for_interrupt_instr) begin
          mode_next = `PSMC_MODE_WAIT;
          prio_next = `PSMC_PRIO_OPEN;
        end else if (halt_instr) begin
          prio_next = `PSMC_PRIO_OPEN;
          if (irq_pending) begin
            mode_next = `PSMC_MODE_RUN;
          end else if (oscillator_interrupt_enable) begin
            mode_next = `PSMC_MODE_AHALT;
          end else begin
            mode_next = `PSMC_MODE_HALT;
          end
        end
      end
      `PSMC_MODE_WAIT: begin
        if (irq_pending) begin
          mode_next = `PSMC_MODE_RUN;
        end
      end
      `PSMC_MODE_AHALT: begin
        if (wake_by_reset) begin
          mode_next = `PSMC_MODE_STAB;
          stab_cnt_next = stab_len;
          stab_from_ahalt_next = 1'b0;
        end else if (irq_timebase || irq_halt_wake) begin
          mode_next = `PSMC_MODE_RUN;
          stab_cnt_next = stab_len;
          stab_from_ahalt_next = 1'b1;
        end
      end
      `PSMC_MODE_HALT: begin
        if (irq_halt_wake || wake_by_reset) begin
          mode_next = `PSMC_MODE_STAB;
          stab_cnt_next = stab_len;
        end
      end
      `PSMC_MODE_STAB: begin
        if (stab_cnt_reg <= 13'h0001) begin
          mode_next = `PSMC_MODE_RUN;
          stab_cnt_next = 13'h0000;
        end else begin
          stab_cnt_next = stab_cnt_reg - 13'h0001;
        end
      end
      default: mode_next = `PSMC_MODE_RUN;
    endcase
    // Clearing oscillator interrupt enable early after active-halt wake goes to stabilisation
    if (mode_reg == `PSMC_MODE_RUN && stab_from_ahalt_reg) begin
      if (stab_cnt_reg == 13'h0000) begin
        stab_from_ahalt_next = 1'b0;
      end else if (!oscillator_interrupt_enable) begin
        mode_next = `PSMC_MODE_STAB;
        stab_from_ahalt_next = 1'b0;
      end else begin
        stab_cnt_next = stab_cnt_reg - 13'h0001;
      end
    end
  end

  // ----------------------------------------
  // Registers and outputs
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      mode_reg <= `PSMC_MODE_RUN;
      clk_status_reg <= `PSMC_CLK_STATUS_RST;
      prio_reg <= `PSMC_PRIO_MASKED;
      stab_cnt_reg <= 13'h0000;
      div_cnt_reg <= 4'h0;
      stab_from_ahalt_reg <= 1'b0;
      reg_rdata <= 8'h00;
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_en <= 1'b1;
      timebase_clk_en <= 1'b1;
      cc_prio <= `PSMC_PRIO_MASKED;
      cc_pushed_prio <= `PSMC_PRIO_MASKED;
      cc_push <= 1'b0;
      vector_fetch <= 1'b0;
      watchdog_reset <= 1'b0;
      mode <= `PSMC_MODE_RUN;
    end else begin
      mode_reg <= mode_next;
      clk_status_reg <= clk_status_next;
      prio_reg <= prio_next;
      stab_cnt_reg <= stab_cnt_next;
      div_cnt_reg <= div_cnt_next;
      stab_from_ahalt_reg <= stab_from_ahalt_next;
      mode <= mode_next;
      cc_prio <= prio_next;
      cc_push <= irq_enter;
      if (irq_enter) begin
        cc_pushed_prio <= prio_reg;
      end
      vector_fetch <= (mode_reg != `PSMC_MODE_RUN) && (mode_next == `PSMC_MODE_RUN);
      cpu_clk_en <= (mode_next == `PSMC_MODE_RUN) && div_tick;
      periph_clk_en <= (mode_next == `PSMC_MODE_RUN || mode_next == `PSMC_MODE_WAIT) && div_tick;
      osc_en <= (mode_next != `PSMC_MODE_HALT);
      timebase_clk_en <= (mode_next != `PSMC_MODE_HALT && mode_next != `PSMC_MODE_STAB);
      watchdog_reset <= watchdog_reset_req && !(mode_reg == `PSMC_MODE_AHALT && oscillator_interrupt_enable);
      if (reg_rd) begin
        case (reg_addr)
          `PSMC_ADDR_CLK_STATUS: reg_rdata <= clk_status_reg;
          `PSMC_ADDR_MODE: reg_rdata <= {5'h00, mode_reg};
          `PSMC_ADDR_CC: reg_rdata <= {6'h00, prio_reg};
          `PSMC_ADDR_STAB_CNT: reg_rdata <= stab_cnt_reg[7:0];
          default: reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule

/* File: tb/psmc_asserts.sv */
// Checker for the power saving mode controller
`timescale 1ns/1ps
module psmc_asserts (
  input logic clk, rst_b, wait_for_interrupt_instr, halt_instr, irq_pending,
  input logic irq_timebase, irq_halt_wake, irq_enter, wake_by_reset, cpu_clk_en,
  input logic periph_clk_en, osc_en, timebase_clk_en, cc_push, vector_fetch, watchdog_reset,
  input logic [1:0] irq_prio, cc_prio,
  input logic [2:0] mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_away; mode != 3'h0; endsequence
  sequence s_back; mode == 3'h0; endsequence
  AST_WAIT_IN: assert property (mode == 3'h0 && wait_for_interrupt_instr && !irq_pending
    |=> mode == 3'h1 && cc_prio == 2'h2) else $error("wait entry wrong");
  AST_WAIT_CLK: assert property (mode == 3'h1 |-> !cpu_clk_en) else $error("cpu runs in wait");
  AST_AHALT_CLK: assert property (mode == 3'h2 |-> osc_en && timebase_clk_en
    && !periph_clk_en && !cpu_clk_en) else $error("active-halt clocks wrong");
  AST_HALT_OSC: assert property (mode == 3'h3 |-> !osc_en && !periph_clk_en) else $error("osc on in halt");
  AST_AHALT_WAKE: assert property (mode == 3'h2 && irq_timebase && !wake_by_reset |=> s_back)
    else $error("no prompt wake");
  AST_AHALT_STAY: assert property (mode == 3'h2 && !irq_timebase && !irq_halt_wake
    && !irq_pending && !wake_by_reset |=> mode == 3'h2) else $error("stray wake");
  AST_VECTOR: assert property (s_away ##1 s_back |-> vector_fetch) else $error("no vector fetch");
  AST_WDOG: assert property (mode == 3'h2 ##1 mode == 3'h2 |-> !watchdog_reset) else $error("watchdog fired");
  AST_PUSH: assert property (irq_enter && mode == 3'h0 && !wait_for_interrupt_instr && !halt_instr
    |=> cc_push && cc_prio == $past(irq_prio)) else $error("push wrong");
  AST_HALT_WAKE: assert property (mode == 3'h3 && irq_halt_wake |=> mode == 3'h4) else $error("no stab");
  AST_AHALT_RST: assert property (mode == 3'h2 && wake_by_reset |=> mode == 3'h4) else $error("no reset stab");
endmodule
bind psmc_top psmc_asserts i_psmc_asserts (.*);

/* File: tb/psmc_cpu_model.sv */
// CPU core model issuing instruction pulses
`timescale 1ns/1ps
module psmc_cpu_model (
  input logic clk,
  input logic [1:0] op,
  output logic wait_for_interrupt_instr,
  output logic halt_instr,
  output logic irq_enter
);
  always @(posedge clk) begin
    wait_for_interrupt_instr <= op == 2'h1;
    halt_instr <= op == 2'h2;
    irq_enter <= op == 2'h3;
  end
endmodule

/* File: tb/psmc_top_tb.sv */
// Testbench for the power saving mode controller
`timescale 1ns/1ps
module psmc_top_tb;
  logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, irq_pending = 0, irq_timebase = 0;
  logic irq_halt_wake = 0, cc_pop = 0, wake_by_reset = 0, watchdog_reset_req = 0;
  logic [1:0] op = 0, irq_prio = 0, cc_pop_prio = 0, cc_prio, cc_pushed_prio;
  logic [3:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, d;
  logic [2:0] mode;
  logic wait_for_interrupt_instr, halt_instr, irq_enter, cpu_clk_en, periph_clk_en;
  logic osc_en, timebase_clk_en, cc_push, vector_fetch, watchdog_reset;
  int miscompares = 0, n_compared = 0, cyc = 0, n, p, seed = 31458;
  int pq[$];
  psmc_cpu_model i_psmc_cpu_model (.*);
  psmc_top #(.STAB_SHORT_CYC(4), .STAB_LONG_CYC(8)) i_psmc_top (.*);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      final_report;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input logic [7:0] s, e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task final_report;
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  task go(input logic [1:0] o);
    @(posedge clk);
    op <= o;
    @(posedge clk);
    op <= 0;
  endtask
  task settle;
    n = 0;
    while (mode !== 3'h0 && n < 50) begin
      step(1);
      n++;
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1;
    step(1);
    chk(mode, 0);
    chk({cc_prio, cpu_clk_en, periph_clk_en, osc_en}, 8'h1f);
    for (int cp = 0; cp < 4; cp++) begin
      wr(4'h0, 8'(2 + 4 * cp));
      rd(4'h0);
      chk(d, 8'(2 + 4 * cp));
      step(16);
      n = 0;
      repeat (64) begin step(1); n += cpu_clk_en; end
      chk(n, 64 >> (cp + 1));
    end
    go(2'h1);
    step(2);
    chk({mode, cc_prio}, 8'h06);
    n = 0;
    repeat (64) begin step(1); n += periph_clk_en; end
    chk(n, 4);
    @(posedge clk) irq_pending <= 1;
    @(posedge clk) irq_pending <= 0;
    step(1);
    chk(mode, 0);
    rd(4'h0);
    chk(d, 8'h0e);
    rd(4'h9);
    chk(d, 0);
    wr(4'h0, 8'h01);
    go(2'h2);
    step(2);
    chk({mode, cc_prio}, 8'h0a);
    chk({cpu_clk_en, periph_clk_en, osc_en, timebase_clk_en}, 8'h03);
    @(posedge clk) watchdog_reset_req <= 1;
    step(3);
    chk({watchdog_reset, mode}, 8'h02);
    @(posedge clk) irq_timebase <= 1;
    watchdog_reset_req <= 0;
    @(posedge clk) irq_timebase <= 0;
    #1 chk({vector_fetch, mode}, 8'h08);
    wr(4'h0, 8'h00);
    step(1);
    chk(mode, 4);
    settle;
    for (int l = 0; l < 2; l++) begin
      wr(4'h0, 8'(l << 4));
      go(2'h2);
      step(2);
      chk({mode, osc_en}, 8'h06);
      @(posedge clk) irq_halt_wake <= 1;
      @(posedge clk) irq_halt_wake <= 0;
      #1 chk(mode, 4);
      settle;
      chk(n >= (4 << l) - 1 && n <= (4 << l) + 1, 1);
    end
    pq.push_back(int'(cc_prio));
    repeat (4) begin
      p = $random(seed) & 3;
      pq.push_back(p);
      @(posedge clk) irq_prio <= 2'(p);
      go(2'h3);
      step(1);
      chk({cc_push, cc_prio}, 8'(4 + p));
      chk(cc_pushed_prio, 8'(pq.pop_front()));
    end
    @(posedge clk) begin cc_pop_prio <= 2'h1; cc_pop <= 1; end
    @(posedge clk) cc_pop <= 0;
    #1 chk(cc_prio, 1);
    @(posedge clk) watchdog_reset_req <= 1;
    @(posedge clk) watchdog_reset_req <= 0;
    #1 chk(watchdog_reset, 1);
    wr(4'h0, 8'h01);
    go(2'h2);
    step(2);
    chk(mode, 2);
    @(posedge clk) wake_by_reset <= 1;
    @(posedge clk) wake_by_reset <= 0;
    #1 chk(mode, 4);
    settle;
    chk(mode, 0);
    final_report;
  end
endmodule
